// >>> verilog/aoc_pkg.sv
// Package with register map, field positions and reset values for the analog output control bank.
package aoc_pkg;
    localparam logic [7:0] AOC_PAGE_STATUS      = 8'h00;
    localparam logic [7:0] AOC_PAGE_ANALOG      = 8'h01;
    localparam logic [7:0] AOC_AUTO_MUTE_STATUS = 8'h78;
    localparam logic [7:0] AOC_AMP_TYPE         = 8'h01;
    localparam logic [7:0] AOC_GAIN_SELECT      = 8'h02;
    localparam logic [7:0] AOC_MUTE_FOLLOW      = 8'h06;
    localparam logic [7:0] AOC_AMP_BOOST        = 8'h07;
    localparam logic [7:0] AOC_DEEMPH_REF       = 8'h09;
    localparam int         AOC_LEFT_BIT         = 4;
    localparam int         AOC_RIGHT_BIT        = 0;
    localparam int         AOC_DEEMPH_BIT       = 1;
    localparam int         AOC_REFPD_BIT        = 0;
    localparam logic [7:0] AOC_STATUS_RW_MASK   = 8'hEE;
    localparam logic [7:0] AOC_AMP_TYPE_RST     = 8'h00;
    localparam logic [7:0] AOC_GAIN_RST         = 8'h00;
    localparam logic [7:0] AOC_MUTE_FOLLOW_RST  = 8'h01;
    localparam logic [7:0] AOC_BOOST_RST        = 8'h00;
    localparam logic [7:0] AOC_DEEMPH_REF_RST   = 8'h01;
    localparam logic [7:0] AOC_STATUS_RST       = 8'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aoc_req_t;

    typedef struct packed {
        logic amplitude_type_select;
        logic left_gain_half;
        logic right_gain_half;
        logic analog_mute_follow_enable;
        logic left_amplitude_boost;
        logic right_amplitude_boost;
        logic pin_deemphasis_enable;
        logic reference_power_down;
    } aoc_ctrl_t;
endpackage : aoc_pkg

// >>> verilog/aoc_regs.sv
// Register bank for the analog output path: auto-mute status and analog controls.
`timescale 1ns/1ps
// Behaviour
// RULE1: Left auto-mute flag reads at bit 4 of page 0 register 0x78.
// RULE2: Right auto-mute flag reads at bit 0 of that same register.
// RULE3: Page 1 reg 0x01 bit 0, reset 0, picks supply-proportional amplitude.
// RULE4: Host disables clock autoset and sets dividers when that mode uses PLL; this bank has no clock or divider logic.
// RULE5: Page 1 reg 0x02 bit 4, reset 0, sets left gain to -6 dB.
// RULE6: Page 1 reg 0x02 bit 0, reset 0, sets right gain to -6 dB.
// RULE7: Page 1 reg 0x06 bit 0, reset 1, lets analog mute follow digital mute.
// RULE8: Page 1 reg 0x07 bit 4, reset 0, boosts left amplitude ten percent.
// RULE9: Page 1 reg 0x07 bit 0, reset 0, boosts right amplitude ten percent.
// RULE10: Page 1 reg 0x09 bit 1, reset 0, lets shared pin drive de-emphasis.
// RULE11: Page 1 reg 0x09 bit 0, reset 1, powers down the common-mode reference.
// RULE12: Reserved bits reset to zero, keep written values, affect nothing.
module aoc_regs (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire aoc_pkg::aoc_req_t req,
    input  wire logic              left_auto_mute,
    input  wire logic              right_auto_mute,
    output logic [7:0]             rdata,
    output logic                   rvalid,
    output aoc_pkg::aoc_ctrl_t     ctrl
);
    import aoc_pkg::*;

    logic [7:0] status_rw_reg;
    logic [7:0] flags_reg;
    logic [7:0] amp_type_reg;
    logic [7:0] gain_reg;
    logic [7:0] follow_reg;
    logic [7:0] boost_reg;
    logic [7:0] deemph_reg;
    logic [7:0] rdata_next;

    wire pg0     = (req.page == AOC_PAGE_STATUS);
    wire pg1     = (req.page == AOC_PAGE_ANALOG);
    wire hit_st  = pg0 && (req.addr == AOC_AUTO_MUTE_STATUS);
    wire hit_at  = pg1 && (req.addr == AOC_AMP_TYPE);
    wire hit_gn  = pg1 && (req.addr == AOC_GAIN_SELECT);
    wire hit_fl  = pg1 && (req.addr == AOC_MUTE_FOLLOW);
    wire hit_bs  = pg1 && (req.addr == AOC_AMP_BOOST);
    wire hit_de  = pg1 && (req.addr == AOC_DEEMPH_REF);
    wire hit_any = hit_st | hit_at | hit_gn | hit_fl | hit_bs | hit_de;

    // Flags are sampled into a register so the read path and outputs stay flop-driven.
    wire [7:0] flags_next = {3'h0, left_auto_mute, 3'h0, right_auto_mute}; // RULE1 RULE2

    // Status reads merge the sampled flags in flags_reg with the writable reserved bits; writes cannot touch flags.
    wire [7:0] status_view = (status_rw_reg & AOC_STATUS_RW_MASK) | flags_reg; // RULE1 RULE2 RULE12

    assign rdata_next = hit_st ? status_view  :
                        hit_at ? amp_type_reg :
                        hit_gn ? gain_reg     :
                        hit_fl ? follow_reg   :
                        hit_bs ? boost_reg    :
                        hit_de ? deemph_reg   : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_rw_reg <= AOC_STATUS_RST;
            flags_reg     <= AOC_STATUS_RST;
            amp_type_reg  <= AOC_AMP_TYPE_RST;    // RULE3
            gain_reg      <= AOC_GAIN_RST;        // RULE5 RULE6
            follow_reg    <= AOC_MUTE_FOLLOW_RST; // RULE7
            boost_reg     <= AOC_BOOST_RST;       // RULE8 RULE9
            deemph_reg    <= AOC_DEEMPH_REF_RST;  // RULE10 RULE11
            rdata         <= 8'h00;
            rvalid        <= 1'h0;
        end else begin
            flags_reg <= flags_next;
            rvalid    <= req.rd;
            if (req.rd) begin
                rdata <= rdata_next;
            end
            // Whole bytes are stored, status minus its flag bits, so reserved bits hold what was written.
            if (req.wr && hit_st) status_rw_reg <= req.wdata & AOC_STATUS_RW_MASK; // RULE12
            if (req.wr && hit_at) amp_type_reg  <= req.wdata; // RULE3 RULE12
            if (req.wr && hit_gn) gain_reg      <= req.wdata; // RULE5 RULE6
            if (req.wr && hit_fl) follow_reg    <= req.wdata; // RULE7
            if (req.wr && hit_bs) boost_reg     <= req.wdata; // RULE8 RULE9
            if (req.wr && hit_de) deemph_reg    <= req.wdata; // RULE10 RULE11
        end
    end

    // Controls are a direct slice of stored bits, so reserved bits never reach the analog path.
    always_comb begin
        ctrl.amplitude_type_select     = amp_type_reg[AOC_RIGHT_BIT];   // RULE3
        ctrl.left_gain_half            = gain_reg[AOC_LEFT_BIT];        // RULE5
        ctrl.right_gain_half           = gain_reg[AOC_RIGHT_BIT];       // RULE6
        ctrl.analog_mute_follow_enable = follow_reg[AOC_RIGHT_BIT];     // RULE7
        ctrl.left_amplitude_boost      = boost_reg[AOC_LEFT_BIT];       // RULE8
        ctrl.right_amplitude_boost     = boost_reg[AOC_RIGHT_BIT];      // RULE9
        ctrl.pin_deemphasis_enable     = deemph_reg[AOC_DEEMPH_BIT];    // RULE10
        ctrl.reference_power_down      = deemph_reg[AOC_REFPD_BIT];     // RULE11
    end

    // Named steps of the register traffic that the properties below are built from.
    // A flag read only counts once the flag flop has left reset, since that flop lags its pin by one edge.
    sequence s_flag_read;
        req.rd && hit_st && $past(rst_b);
    endsequence

    sequence s_status_write;
        req.wr && hit_st;
    endsequence

    sequence s_status_readback;
        req.rd && hit_st && !req.wr;
    endsequence

    sequence s_amp_type_write;
        req.wr && hit_at;
    endsequence

    sequence s_gain_write;
        req.wr && hit_gn;
    endsequence

    sequence s_gain_readback;
        req.rd && hit_gn && !req.wr;
    endsequence

    sequence s_gain_read_beside_write;
        req.rd && hit_gn && req.wr;
    endsequence

    sequence s_follow_write;
        req.wr && hit_fl;
    endsequence

    sequence s_boost_write;
        req.wr && hit_bs;
    endsequence

    sequence s_deemph_write;
        req.wr && hit_de;
    endsequence

    // A status read shows the pins as they stood two edges before the answer.
    a_left_flag_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
        s_flag_read |=> rdata[AOC_LEFT_BIT] == $past(left_auto_mute, 2))
        else $error("Left auto-mute flag read wrong.");

    a_right_flag_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
        s_flag_read |=> rdata[AOC_RIGHT_BIT] == $past(right_auto_mute, 2))
        else $error("Right auto-mute flag read wrong.");

    a_status_flags_ro: assert property (@(posedge clk) disable iff (!rst_b) // RULE1 RULE2
        s_status_write ##1 s_flag_read |=>
            (rdata & ~AOC_STATUS_RW_MASK) == {3'h0, $past(left_auto_mute, 2), 3'h0, $past(right_auto_mute, 2)})
        else $error("Status write reached a flag bit.");

    a_status_reserved_keep: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
        s_status_write ##1 s_status_readback |=>
            (rdata & AOC_STATUS_RW_MASK) == ($past(req.wdata, 2) & AOC_STATUS_RW_MASK))
        else $error("Status reserved bits not kept.");

    a_amp_type_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
        s_amp_type_write |=> ctrl.amplitude_type_select == $past(req.wdata[0]))
        else $error("Amplitude type not updated.");

    a_left_gain_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
        s_gain_write |=> ctrl.left_gain_half == $past(req.wdata[4]))
        else $error("Left gain not updated.");

    a_right_gain_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
        s_gain_write |=> ctrl.right_gain_half == $past(req.wdata[0]))
        else $error("Right gain not updated.");

    a_follow_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
        s_follow_write |=> ctrl.analog_mute_follow_enable == $past(req.wdata[0]))
        else $error("Mute follow not updated.");

    a_follow_reset_val: assert property (@(posedge clk) // RULE7
        !rst_b |=> ctrl.analog_mute_follow_enable)
        else $error("Mute follow not enabled after reset.");

    a_left_boost_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
        s_boost_write |=> ctrl.left_amplitude_boost == $past(req.wdata[4]))
        else $error("Left boost not updated.");

    a_right_boost_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
        s_boost_write |=> ctrl.right_amplitude_boost == $past(req.wdata[0]))
        else $error("Right boost not updated.");

    a_boost_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE8 RULE9
        !(req.wr && hit_bs) |=> $stable({ctrl.left_amplitude_boost, ctrl.right_amplitude_boost}))
        else $error("Boost changed without a write.");

    a_deemph_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
        s_deemph_write |=> ctrl.pin_deemphasis_enable == $past(req.wdata[1]))
        else $error("De-emphasis select not updated.");

    a_refpd_write: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
        s_deemph_write |=> ctrl.reference_power_down == $past(req.wdata[0]))
        else $error("Reference power-down not updated.");

    a_refpd_reset_val: assert property (@(posedge clk) // RULE11
        !rst_b |=> ctrl.reference_power_down && !ctrl.pin_deemphasis_enable)
        else $error("Reference power-down reset value wrong.");

    a_ctrl_reset_zero: assert property (@(posedge clk) // RULE3 RULE5 RULE6 RULE8 RULE9
        !rst_b |=> !ctrl.amplitude_type_select && !ctrl.left_gain_half && !ctrl.right_gain_half &&
                   !ctrl.left_amplitude_boost && !ctrl.right_amplitude_boost)
        else $error("Controls not cleared by reset.");

    a_reserved_keep: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
        s_gain_write ##1 s_gain_readback |=> rdata == $past(req.wdata, 2))
        else $error("Reserved bits not kept.");

    // A read beside a write must answer with the value stored before that write.
    a_read_old_value: assert property (@(posedge clk) disable iff (!rst_b) // RULE5 RULE6
        s_gain_write ##1 s_gain_read_beside_write |=> rdata == $past(req.wdata, 2))
        else $error("Read beside a write returned the new value.");

    a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd |=> rvalid)
        else $error("Read not answered.");

    a_rvalid_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        !req.rd |=> !rvalid)
        else $error("Read valid without a read.");

    a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !req.rd |=> $stable(rdata))
        else $error("Read data changed without a read.");

    a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
        req.rd && !hit_any |=> rdata == 8'h00)
        else $error("Unmapped read not zero.");

    a_unmapped_write_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        req.wr && !hit_any |=> $stable(ctrl))
        else $error("Unmapped write changed a control.");

    a_reset_outputs: assert property (@(posedge clk)
        !rst_b |=> rdata == 8'h00 && !rvalid)
        else $error("Read outputs not cleared by reset.");
endmodule : aoc_regs

// >>> testbench/aoc_regs_tb.sv
// Self-checking bench for the analog output control register bank.
`timescale 1ns/1ps
module aoc_regs_tb;
    import aoc_pkg::*;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    aoc_req_t   req = '0;
    logic       left_auto_mute = 1'b0;
    logic       right_auto_mute = 1'b0;
    logic [7:0] rdata;
    logic       rvalid;
    aoc_ctrl_t  ctrl;
    logic [7:0] mdl [0:5];
    logic [7:0] adr [0:5];
    logic [7:0] d;
    int         i;
    int         bad_count = 0;
    int         tests_run = 0;
    int         cycles = 0;
    aoc_regs dut_u (.clk(clk), .rst_b(rst_b), .req(req), .left_auto_mute(left_auto_mute),
        .right_auto_mute(right_auto_mute), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            summarize();
        end
    end
    function automatic aoc_ctrl_t exp_ctrl();
        return '{mdl[1][0], mdl[2][4], mdl[2][0], mdl[3][0], mdl[4][4], mdl[4][0], mdl[5][1], mdl[5][0]};
    endfunction : exp_ctrl
    function automatic logic [7:0] pg_of(input int k);
        return (k == 0) ? AOC_PAGE_STATUS : AOC_PAGE_ANALOG;
    endfunction : pg_of
    function automatic logic [7:0] exp_flags();
        return {3'h0, left_auto_mute, 3'h0, right_auto_mute};
    endfunction : exp_flags
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check8
    // Starts on a rising edge; the strobe is sampled one edge later and dropped there.
    task automatic xfer(input logic w, input logic [7:0] pg, input logic [7:0] a, input logic [7:0] wd,
                        input logic [7:0] exp);
        req <= '{wr: w, rd: !w, page: pg, addr: a, wdata: wd};
        @(posedge clk);
        req <= '0;
        #1;
        if (!w) check8("rvalid", 8'h01, {7'h00, rvalid});
        if (w) check8("rvalid", 8'h00, {7'h00, rvalid});
        if (!w) check8("rdata", exp, rdata);
        @(posedge clk);
    endtask : xfer
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial begin
        void'($urandom(32'hE4094C41));
        adr = '{AOC_AUTO_MUTE_STATUS, AOC_AMP_TYPE, AOC_GAIN_SELECT, AOC_MUTE_FOLLOW, AOC_AMP_BOOST, AOC_DEEMPH_REF};
        mdl = '{AOC_STATUS_RST, AOC_AMP_TYPE_RST, AOC_GAIN_RST, AOC_MUTE_FOLLOW_RST, AOC_BOOST_RST, 8'h01};
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        check8("ctrl", exp_ctrl(), ctrl);
        for (int k = 0; k < 6; k++) xfer(1'b0, pg_of(k), adr[k], 8'h00, mdl[k]);
        // The first passes set every bit and then clear every bit before random traffic.
        // No clock setup sits behind this bank, so supply-proportional mode needs no divider setup first.
        for (int n = 0; n < 60; n++) begin
            i = (n < 12) ? n % 6 : $urandom_range(5);
            d = (n < 6) ? 8'hFF : (n < 12) ? 8'h00 : 8'($urandom);
            left_auto_mute <= 1'($urandom);
            right_auto_mute <= 1'($urandom);
            xfer(1'b1, pg_of(i), adr[i], d, 8'h00);
            mdl[i] = (i == 0) ? (d & AOC_STATUS_RW_MASK) : d;
            check8("ctrl", exp_ctrl(), ctrl);
            d = (i == 0) ? {3'h0, left_auto_mute, 3'h0, right_auto_mute} : 8'h00;
            xfer(1'b0, pg_of(i), adr[i], 8'h00, mdl[i] | d);
        end
        // Back-to-back pairs: status write then read, gain write then read, gain write then read beside a write.
        for (int k = 0; k < 3; k++) begin
            i = (k == 0) ? 0 : 2;
            d = 8'($urandom);
            req <= '{wr: 1'h1, rd: 1'h0, page: pg_of(i), addr: adr[i], wdata: d};
            @(posedge clk);
            req <= '{wr: 1'(k == 2), rd: 1'h1, page: pg_of(i), addr: adr[i], wdata: ~d};
            @(posedge clk);
            req <= '0;
            #1;
            check8("rdata", (i == 0) ? ((d & AOC_STATUS_RW_MASK) | exp_flags()) : d, rdata);
            mdl[i] = (k == 2) ? ~d : (i == 0) ? (d & AOC_STATUS_RW_MASK) : d;
            @(posedge clk);
        end
        xfer(1'h0, AOC_PAGE_ANALOG, AOC_GAIN_SELECT, 8'h00, mdl[2]);
        check8("ctrl", exp_ctrl(), ctrl);
        xfer(1'b1, AOC_PAGE_ANALOG, 8'h03, 8'hFF, 8'h00);
        xfer(1'b0, AOC_PAGE_ANALOG, 8'h03, 8'h00, 8'h00);
        xfer(1'b0, AOC_PAGE_STATUS, AOC_AMP_TYPE, 8'h00, 8'h00);
        check8("ctrl", exp_ctrl(), ctrl);
        // A second reset in mid-run must bring every control and the read outputs back to reset values.
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        mdl = '{AOC_STATUS_RST, AOC_AMP_TYPE_RST, AOC_GAIN_RST, AOC_MUTE_FOLLOW_RST, AOC_BOOST_RST, AOC_DEEMPH_REF_RST};
        #1;
        check8("ctrl", exp_ctrl(), ctrl);
        check8("rdata", 8'h00, rdata);
        check8("rvalid", 8'h00, {7'h00, rvalid});
        @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? exp_flags() : 8'h00;
            xfer(1'h0, pg_of(k), adr[k], 8'h00, mdl[k] | d);
        end
        summarize();
    end
endmodule : aoc_regs_tb
